// *** logic/phy_mgmt_pkg.sv ***
// Constants shared by the PHY management register block
package phy_mgmt_pkg;
  // Register addresses on the management bus
  localparam logic [4:0] REG_IRQ_CTL_STAT = 5'h1b;
  localparam logic [4:0] REG_XOVER_CTL = 5'h1c;
  localparam logic [4:0] REG_PHY_CTL_STAT = 5'h1f;
  // Interrupt register fields: enables in the high byte, sticky flags in the low byte
  localparam int IRQ_EN_LSB = 8;
  localparam int IRQ_EN_MSB = 15;
  localparam int IRQ_ST_LSB = 0;
  localparam int IRQ_ST_MSB = 7;
  localparam int EV_JABBER = 7;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] IRQ_ST_RESET = 8'h00;
  // Crossover register fields
  localparam int XOVER_FORCE_MDI_BIT = 7;
  localparam int XOVER_DISABLE_BIT = 6;
  localparam logic [15:0] XOVER_RESET = 16'h0000;
  // PHY control/status fields
  localparam int PCTL_IRQ_POL_BIT = 14;
  localparam int PCTL_JAB_EN_BIT = 9;
  localparam int PCTL_SPD1000_BIT = 6;
  localparam int PCTL_SPD100_BIT = 5;
  localparam int PCTL_SPD10_BIT = 4;
  localparam int PCTL_DUPLEX_BIT = 3;
  localparam int PCTL_MASTER_BIT = 2;
  localparam int PCTL_LINK_FAIL_BIT = 0;
  localparam logic [15:0] PCTL_RESET = 16'h0200;
  localparam logic [15:0] PCTL_WMASK = 16'hf382;
  // Management frame layout
  localparam logic [5:0] PREAMBLE_BITS = 6'd32;
  localparam logic [4:0] OP_BITS = 5'd2;
  localparam logic [4:0] ADDR_BITS = 5'd10;
  localparam logic [4:0] TA_BITS = 5'd2;
  localparam logic [4:0] DATA_BITS = 5'd16;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  // Frame engine states
  typedef enum logic [2:0] {
    S_PRE,
    S_START,
    S_OP,
    S_ADDR,
    S_TA,
    S_RDATA,
    S_WDATA
  } mdio_state_t;
endpackage

// *** logic/sync_2ff.sv ***
// Two flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// *** logic/phy_irq_mdix_status_regs.sv ***
// Vendor management registers: interrupts, crossover override, PHY control/status
`timescale 1ns/1ps
// Function
// - Enables for jabber, receive error, page received
// - Bit 12 enables parallel detect fault interrupt
// - Bit 11 enables link partner acknowledge interrupt
// - Bit 10 enables link-down interrupt
// - Bit 9 enables remote fault interrupt
// - Bit 8 enables link-up interrupt
// - Jabber flag latches, cleared by read
// - Receive error flag latches, cleared by read
// - Page received flag latches, cleared by read
// - Parallel detect fault flag, cleared by read
// - Partner acknowledge flag, cleared by read
// - Link-down flag latches, cleared by read
// - Remote fault flag latches, cleared by read
// - Link-up flag latches, cleared by read
// - Crossover disable bit stops automatic pair selection
// - Forced bit picks MDI or MDI-X
// - Forced bit ignored while automatic crossover on
// - Bit 14 sets interrupt output polarity
// - Bit 9 enables jabber counter, resets one
// - Bits 6..4 report resolved speed
// - Bit 3 reports resolved duplex
// - Bit 2 reports gigabit master or slave
module phy_irq_mdix_status_regs
  import phy_mgmt_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Management pins (MDIO is two-way)
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [4:0] phy_addr_i,
  // Events from the PHY core, order jabber..link-up
  input wire logic [7:0] event_i,
  // Resolved status from the PHY core
  input wire logic speed_1000_i,
  input wire logic speed_100_i,
  input wire logic speed_10_i,
  input wire logic duplex_full_i,
  input wire logic master_i,
  input wire logic link_check_fail_i,
  input wire logic auto_pair_mdi_i,
  // Controls to the PHY core
  output logic auto_crossover_en_o,
  output logic pair_mdi_o,
  output logic jabber_cnt_en_o,
  output logic irq_o
);
  logic [1:0] rst_q;
  logic rstn;
  logic mdc_s;
  logic mdio_s;
  logic mdc_d1_q;
  logic mdc_rise;
  mdio_state_t state_q;
  logic [5:0] pre_cnt_q;
  logic [4:0] bit_cnt_q;
  logic [1:0] op_q;
  logic [9:0] addr_q;
  logic [15:0] shift_q;
  logic [15:0] rd_data;
  logic addr_hit;
  logic [4:0] reg_sel;
  logic rd_latch;
  logic wr_stb;
  logic [7:0] clr_mask;
  logic [7:0] ev_set;
  logic [7:0] ien_q;
  logic [7:0] ist_q;
  logic [15:0] xover_q;
  logic [15:0] pctl_q;
  logic irq_active;

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rstn = rst_q[1];

  // Pins come from the host's domain
  sync_2ff #(
    .WIDTH(2),
    .RESET_VAL(2'b01)
  ) u_sync (
    .clock_i(clock_i),
    .resetn_i(rstn),
    .async_i({mdc_i, mdio_i}),
    .sync_o({mdc_s, mdio_s})
  );

  // Rising edge of MDC marks each frame bit
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      mdc_d1_q <= 1'b0;
    end else begin
      mdc_d1_q <= mdc_s;
    end
  end
  assign mdc_rise = mdc_s & ~mdc_d1_q;

  // Address compare is only meaningful once all ten header bits are in
  assign addr_hit = (addr_q[9:5] == phy_addr_i);
  assign reg_sel = addr_q[4:0];
  // Read data is captured as the last address bit arrives
  assign rd_latch = mdc_rise && (state_q == S_ADDR) && (bit_cnt_q == ADDR_BITS - 5'd1)
                    && (op_q == OP_READ) && ({addr_q[8:0], mdio_s} >> 5 == {5'h00, phy_addr_i});
  assign wr_stb = mdc_rise && (state_q == S_WDATA) && (bit_cnt_q == DATA_BITS - 5'd1)
                  && (op_q == OP_WRITE) && addr_hit;

  // Frame engine; preamble of 32 ones required before every frame
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_PRE;
      pre_cnt_q <= 6'd0;
      bit_cnt_q <= 5'd0;
      op_q <= 2'b00;
      addr_q <= 10'h000;
    end else if (mdc_rise) begin
      case (state_q)
        S_PRE: begin
          if (mdio_s) begin
            pre_cnt_q <= (pre_cnt_q == PREAMBLE_BITS) ? pre_cnt_q : pre_cnt_q + 6'd1;
          end else begin
            pre_cnt_q <= 6'd0;
            if (pre_cnt_q == PREAMBLE_BITS) begin
              state_q <= S_START;
            end
          end
        end
        S_START: begin
          bit_cnt_q <= 5'd0;
          state_q <= mdio_s ? S_OP : S_PRE;
        end
        S_OP: begin
          op_q <= {op_q[0], mdio_s};
          bit_cnt_q <= bit_cnt_q + 5'd1;
          if (bit_cnt_q == OP_BITS - 5'd1) begin
            bit_cnt_q <= 5'd0;
            state_q <= S_ADDR;
          end
        end
        S_ADDR: begin
          addr_q <= {addr_q[8:0], mdio_s};
          bit_cnt_q <= bit_cnt_q + 5'd1;
          if (bit_cnt_q == ADDR_BITS - 5'd1) begin
            bit_cnt_q <= 5'd0;
            state_q <= S_TA;
          end
        end
        S_TA: begin
          bit_cnt_q <= bit_cnt_q + 5'd1;
          if (bit_cnt_q == TA_BITS - 5'd1) begin
            bit_cnt_q <= 5'd0;
            state_q <= (op_q == OP_READ) ? S_RDATA : S_WDATA;
          end
        end
        S_RDATA, S_WDATA: begin
          bit_cnt_q <= bit_cnt_q + 5'd1;
          if (bit_cnt_q == DATA_BITS - 5'd1) begin
            bit_cnt_q <= 5'd0;
            state_q <= S_PRE;
          end
        end
        default: begin
          state_q <= S_PRE;
        end
      endcase
    end
  end

  // Data shifter: read word loaded at address end, write word shifted in
  // Every read data rise moves one bit up, so bit 14 always holds the next bit out
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 16'h0000;
    end else if (rd_latch) begin
      shift_q <= rd_data;
    end else if (mdc_rise && state_q == S_RDATA) begin
      shift_q <= {shift_q[14:0], 1'b0};
    end else if (mdc_rise && state_q == S_WDATA) begin
      shift_q <= {shift_q[14:0], mdio_s};
    end
  end

  // Pin drive: zero in the second turnaround bit, then data MSB first.
  // Output moves a few clocks after the MDC rise, so host hold is ample.
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      mdio_oe_o <= 1'b0;
      mdio_o <= 1'b1;
    end else if (mdc_rise) begin
      if (state_q == S_TA && bit_cnt_q == 5'd0 && op_q == OP_READ && addr_hit) begin
        mdio_oe_o <= 1'b1;
        mdio_o <= 1'b0;
      end else if (state_q == S_TA && mdio_oe_o) begin
        mdio_o <= shift_q[15];
      end else if (state_q == S_RDATA && mdio_oe_o && bit_cnt_q != DATA_BITS - 5'd1) begin
        mdio_o <= shift_q[14];
      end else begin
        mdio_oe_o <= 1'b0;
        mdio_o <= 1'b1;
      end
    end
  end

  // Register read image; register index taken from the bit now arriving
  always_comb begin
    rd_data = 16'h0000;
    case ({addr_q[3:0], mdio_s})
      REG_IRQ_CTL_STAT: begin
        rd_data = {ien_q, ist_q};
      end
      REG_XOVER_CTL: begin
        rd_data = xover_q;
      end
      REG_PHY_CTL_STAT: begin
        rd_data = pctl_q & PCTL_WMASK;
        rd_data[PCTL_SPD1000_BIT] = speed_1000_i;
        rd_data[PCTL_SPD100_BIT] = speed_100_i;
        rd_data[PCTL_SPD10_BIT] = speed_10_i;
        rd_data[PCTL_DUPLEX_BIT] = duplex_full_i;
        rd_data[PCTL_MASTER_BIT] = master_i;
        rd_data[PCTL_LINK_FAIL_BIT] = link_check_fail_i;
      end
      default: begin
        rd_data = 16'h0000;
      end
    endcase
  end

  // Interrupt enables, writable byte of the interrupt register
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      ien_q <= IRQ_EN_RESET;
    end else if (wr_stb && reg_sel == REG_IRQ_CTL_STAT) begin
      ien_q <= shift_q[14:7];
    end
  end

  // Jabber detection is off while its counter is disabled
  assign ev_set = event_i & {jabber_cnt_en_o, 7'h7f};
  assign clr_mask = (rd_latch && {addr_q[3:0], mdio_s} == REG_IRQ_CTL_STAT) ? ist_q : 8'h00;

  // Sticky flags; an event in the reading cycle survives the clear
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      ist_q <= IRQ_ST_RESET;
    end else begin
      ist_q <= (ist_q & ~clr_mask) | ev_set;
    end
  end

  // Crossover and PHY control storage; read-only bits never stored
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      xover_q <= XOVER_RESET;
      pctl_q <= PCTL_RESET;
    end else if (wr_stb && reg_sel == REG_XOVER_CTL) begin
      xover_q <= {shift_q[14:0], mdio_s};
    end else if (wr_stb && reg_sel == REG_PHY_CTL_STAT) begin
      pctl_q <= {shift_q[14:0], mdio_s} & PCTL_WMASK;
    end
  end

  // Pair selection: forced bit only counts with automatic crossover off
  assign auto_crossover_en_o = ~xover_q[XOVER_DISABLE_BIT];
  assign pair_mdi_o = xover_q[XOVER_DISABLE_BIT] ? xover_q[XOVER_FORCE_MDI_BIT]
                      : auto_pair_mdi_i;
  assign jabber_cnt_en_o = pctl_q[PCTL_JAB_EN_BIT];

  // Interrupt pin at the programmed polarity
  // Combinational so the pin releases in the same cycle the read clears the flags
  assign irq_active = |(ist_q & ien_q);
  assign irq_o = pctl_q[PCTL_IRQ_POL_BIT] ? irq_active : ~irq_active;

  // All checks run on the system clock and stay quiet until reset is released
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn);

  status_set_a: assert property ((|ev_set) |=> ((ist_q & $past(ev_set)) == $past(ev_set)))
    else $error("event did not latch its flag");
  read_clear_a: assert property ((|clr_mask) && (ev_set == 8'h00) |=> ist_q == 8'h00)
    else $error("flag survived a read with no event");
  flag_hold_a: assert property ((clr_mask == 8'h00) |=> ist_q == ($past(ist_q) | $past(ev_set)))
    else $error("flag changed without event or read");
  irq_high_a: assert property (pctl_q[PCTL_IRQ_POL_BIT] |-> irq_o == |(ist_q & ien_q))
    else $error("active high interrupt wrong");
  irq_low_a: assert property (!pctl_q[PCTL_IRQ_POL_BIT] |-> irq_o == ~|(ist_q & ien_q))
    else $error("active low interrupt wrong");
  forced_pair_a: assert property (xover_q[XOVER_DISABLE_BIT] |->
    pair_mdi_o == xover_q[XOVER_FORCE_MDI_BIT])
    else $error("forced pair mode not applied");
  auto_pair_a: assert property (!xover_q[XOVER_DISABLE_BIT] |-> pair_mdi_o == auto_pair_mdi_i)
    else $error("forced bit leaked into automatic mode");
  jab_gate_a: assert property (!jabber_cnt_en_o |-> !ev_set[EV_JABBER])
    else $error("jabber flagged while counter disabled");
  enable_write_a: assert property (wr_stb && reg_sel == REG_IRQ_CTL_STAT |=>
    ien_q == $past(shift_q[14:7]))
    else $error("enable byte not written");
  speed_read_a: assert property (rd_latch && {addr_q[3:0], mdio_s} == REG_PHY_CTL_STAT |=>
    shift_q[6:4] == {$past(speed_1000_i), $past(speed_100_i), $past(speed_10_i)})
    else $error("speed bits not captured");
  ta_zero_a: assert property ($rose(mdio_oe_o) |-> !mdio_o)
    else $error("turnaround bit not driven low");

  // Register image and write checks
  irq_image_a: assert property (rd_latch && {addr_q[3:0], mdio_s} == REG_IRQ_CTL_STAT |=>
    shift_q == {$past(ien_q), $past(ist_q)})
    else $error("interrupt register image wrong");
  enable_hold_a: assert property (!(wr_stb && reg_sel == REG_IRQ_CTL_STAT) |=>
    $stable(ien_q))
    else $error("enable byte changed without a write");
  xover_write_a: assert property (wr_stb && reg_sel == REG_XOVER_CTL |=>
    auto_crossover_en_o == !$past(shift_q[5]))
    else $error("crossover disable not written");
  pol_write_a: assert property (wr_stb && reg_sel == REG_PHY_CTL_STAT |=>
    pctl_q[PCTL_IRQ_POL_BIT] == $past(shift_q[13]))
    else $error("interrupt polarity not written");
  duplex_rd_a: assert property (rd_latch && {addr_q[3:0], mdio_s} == REG_PHY_CTL_STAT |=>
    shift_q[PCTL_DUPLEX_BIT] == $past(duplex_full_i))
    else $error("duplex bit not captured");
  master_rd_a: assert property (rd_latch && {addr_q[3:0], mdio_s} == REG_PHY_CTL_STAT |=>
    shift_q[PCTL_MASTER_BIT] == $past(master_i))
    else $error("master bit not captured");
  fail_rd_a: assert property (rd_latch && {addr_q[3:0], mdio_s} == REG_PHY_CTL_STAT |=>
    shift_q[PCTL_LINK_FAIL_BIT] == $past(link_check_fail_i))
    else $error("link check bit not captured");

  read_irq_c: cover property (rd_latch && {addr_q[3:0], mdio_s} == REG_IRQ_CTL_STAT);
  write_xover_c: cover property (wr_stb && reg_sel == REG_XOVER_CTL);
  irq_fire_c: cover property ($rose(irq_active));
  set_on_clear_c: cover property ((|clr_mask) && (|(clr_mask & ev_set)));
  write_pctl_c: cover property (wr_stb && reg_sel == REG_PHY_CTL_STAT);
endmodule

// *** verif/mdio_host_model.sv ***
// Management host model: clocks MDC and runs whole MDIO frames
`timescale 1ns/1ps
module mdio_host_model
  import phy_mgmt_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Management pins
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic mdio_i
);
  // MDC stands low between frames; period 21 clocks, just above 200 ns
  localparam int HALF = 10;
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // One bit: set data while MDC low, rise, sample the wire at the rise
  task automatic bit_cycle(input logic drv, input logic val, output logic smp);
    @(posedge clock_i);
    mdio_oe_o <= drv;
    mdio_o <= val;
    repeat (HALF) @(posedge clock_i);
    mdc_o <= 1'b1;
    smp = mdio_i;
    repeat (HALF) @(posedge clock_i);
    mdc_o <= 1'b0;
  endtask
  // Full frame with its own preamble; on reads TA and data are released
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [13:0] hdr;
    logic smp;
    logic rd;
    rd = (op == OP_READ);
    hdr = {2'b01, op, phy, ra};
    for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, smp);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], smp);
    bit_cycle(!rd, 1'b1, smp);
    bit_cycle(!rd, 1'b0, smp);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(!rd, wd[i], smp);
      rdat[i] = smp;
    end
    @(posedge clock_i);
    mdio_oe_o <= 1'b0;
    repeat (HALF) @(posedge clock_i);
  endtask
endmodule

// *** verif/test_phy_irq_mdix_status_regs.sv ***
// Bench for the PHY management register block, driven over MDC/MDIO
`timescale 1ns/1ps
module test_phy_irq_mdix_status_regs;
  import phy_mgmt_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic mdc, host_do, host_oe, dev_do, dev_oe, mdio_wire;
  logic [4:0] phy_addr = 5'h03;
  logic [7:0] event_in = 8'h00;
  logic [5:0] st = 6'b000000;
  logic auto_mdi = 1'b0;
  logic xover_en, pair_mdi, jab_en, irq;
  logic [7:0] en;
  logic [15:0] d;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  // Status rows: 1000, 100, 10, full duplex, master, link fail
  logic [5:0] rows [4] = '{6'b100110, 6'b010001, 6'b001000, 6'b000000};

  always #5 clock = ~clock;
  // Pull-up on MDIO when nobody drives it
  assign mdio_wire = dev_oe ? dev_do : (host_oe ? host_do : 1'b1);

  phy_irq_mdix_status_regs phy_irq_mdix_status_regs_inst (
    .clock_i(clock), .resetn_i(resetn), .mdc_i(mdc), .mdio_i(mdio_wire),
    .mdio_o(dev_do), .mdio_oe_o(dev_oe), .phy_addr_i(phy_addr), .event_i(event_in),
    .speed_1000_i(st[5]), .speed_100_i(st[4]), .speed_10_i(st[3]), .duplex_full_i(st[2]),
    .master_i(st[1]), .link_check_fail_i(st[0]), .auto_pair_mdi_i(auto_mdi),
    .auto_crossover_en_o(xover_en), .pair_mdi_o(pair_mdi), .jabber_cnt_en_o(jab_en),
    .irq_o(irq));
  mdio_host_model mdio_host_model_inst (
    .clock_i(clock), .mdc_o(mdc), .mdio_o(host_do), .mdio_oe_o(host_oe), .mdio_i(mdio_wire));

  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp, input string m);
    check16({15'h0000, got}, {15'h0000, exp}, m);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    mdio_host_model_inst.frame(OP_WRITE, phy_addr, a, v, d);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp, input string m);
    mdio_host_model_inst.frame(OP_READ, phy_addr, a, 16'h0000, d);
    check16(d, exp, m);
  endtask
  // One-cycle event pulse, then let the flag land
  task automatic pulse(input int i);
    @(posedge clock);
    event_in[i] <= 1'b1;
    @(posedge clock);
    event_in <= 8'h00;
    repeat (3) @(posedge clock);
  endtask
  task results;
    $display("Errors %0d of %0d compares", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard: about 53k cycles expected
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      results();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (10) @(posedge clock);
    check1(jab_en, 1'b1, "jab en rst");
    check1(irq, 1'b1, "irq idle low pol");
    check1(xover_en, 1'b1, "auto xover rst");
    rdchk(REG_IRQ_CTL_STAT, 16'h0000, "1b rst");
    rdchk(REG_XOVER_CTL, 16'h0000, "1c rst");
    rdchk(REG_PHY_CTL_STAT, 16'h0200, "1f rst");
    // Flags are read-only: writing ones leaves them clear
    wr(REG_IRQ_CTL_STAT, 16'hffff);
    rdchk(REG_IRQ_CTL_STAT, 16'hff00, "1b rw");
    wr(REG_IRQ_CTL_STAT, 16'h0000);
    // Each event first lands while masked, then its enable is set
    for (int i = 0; i < 8; i++) begin
      en = 8'h01 << i;
      pulse(i);
      check1(irq, 1'b1, "masked");
      wr(REG_IRQ_CTL_STAT, {en, 8'h00});
      check1(irq, 1'b0, "enabled");
      rdchk(REG_IRQ_CTL_STAT, {en, en}, "flag");
      check1(irq, 1'b1, "cleared");
    end
    // Jabber counter off: jabber no longer flagged
    wr(REG_PHY_CTL_STAT, 16'h0000);
    check1(jab_en, 1'b0, "jab off");
    pulse(EV_JABBER);
    rdchk(REG_IRQ_CTL_STAT, 16'h8000, "jab gated");
    // Active-high interrupt polarity
    wr(REG_PHY_CTL_STAT, 16'h4200);
    check1(irq, 1'b0, "irq idle high pol");
    pulse(EV_JABBER);
    check1(irq, 1'b1, "irq high");
    rdchk(REG_IRQ_CTL_STAT, 16'h8080, "jab flag");
    check1(irq, 1'b0, "irq released");
    // Wrong PHY address: wire stays pulled up and the flag survives
    pulse(0);
    mdio_host_model_inst.frame(OP_READ, 5'h04, REG_IRQ_CTL_STAT, 16'h0000, d);
    check16(d, 16'hffff, "other phy");
    rdchk(REG_IRQ_CTL_STAT, 16'h8001, "kept flag");
    rdchk(5'h05, 16'h0000, "unmapped");
    // Crossover: forced bit ignored until automatic mode is off
    wr(REG_XOVER_CTL, 16'h0080);
    auto_mdi <= 1'b0;
    repeat (2) @(posedge clock);
    check1(pair_mdi, 1'b0, "auto mdix");
    auto_mdi <= 1'b1;
    wr(REG_XOVER_CTL, 16'hff40);
    check1(xover_en, 1'b0, "xover off");
    check1(pair_mdi, 1'b0, "forced mdix");
    auto_mdi <= 1'b0;
    wr(REG_XOVER_CTL, 16'h00c0);
    check1(pair_mdi, 1'b1, "forced mdi");
    rdchk(REG_XOVER_CTL, 16'h00c0, "1c rw");
    // Resolved status bits
    for (int k = 0; k < 4; k++) begin
      st <= rows[k];
      repeat (3) @(posedge clock);
      rdchk(REG_PHY_CTL_STAT, 16'h4200 | {9'h000, rows[k][5:1], 1'b0, rows[k][0]}, "status");
    end
    wr(REG_PHY_CTL_STAT, 16'hffff);
    rdchk(REG_PHY_CTL_STAT, 16'hf382, "1f mask");
    results();
  end
endmodule
